// file: slrd_pkg.sv
// Purpose: constants for the twelve-channel serial-in latch driver
// Assumes: one 20 MHz clock; all serial pins sampled through two flip-flops
// Notes: no software-visible registers
package slrd_pkg;
	localparam int unsigned STAGES = 12;
	localparam logic [11:0] CLEAR_VALUE = 12'h000;
	localparam int unsigned SYNC_DEPTH = 2;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned BUF_DEPTH = 2;
endpackage

// file: slrd_driver.sv
// Purpose: serial-in, parallel-out shift register, storage latch, sinks
// Assumes: shift and latch clocks are slow pins, oversampled by clk
// Notes: pin edges are found after a two-flop synchroniser
module slrd_driver #(
	parameter int unsigned STAGES = slrd_pkg::STAGES
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// serial pins
	input wire logic clear_all_n,
	input wire logic shift_clock,
	input wire logic shift_data_in,
	input wire logic latch_clock,
	input wire logic output_enable_n,
	output logic cascade_data_out,
	// sink channels: out is tied low; low on oe_n means pulled down (conducting)
	output logic [STAGES-1:0] sink_channel_outputs,
	output logic [STAGES-1:0] sink_channel_oe_n,
	// parallel word stream from the latch
	output logic word_valid,
	output logic [STAGES-1:0] word_data,
	input wire logic word_ready
);
	logic [1:0] s_clr, s_sck, s_din, s_lck, s_oe;
	logic sck_q, lck_q;
	logic sck_rise, sck_fall, lck_rise, clr_n, oe_n, din;
	logic [STAGES-1:0] shift_reg;
	logic [STAGES-1:0] latch_reg;
	logic [STAGES-1:0] buf_mem [0:1];
	logic [1:0] buf_cnt;
	logic wr_ptr, rd_ptr, buf_in_ready, push, pop;

	// second flop only feeds logic; first flop read by nothing else
	always_ff @(posedge clk) begin
		if (srst) begin
			s_clr <= 2'h0;
			s_sck <= 2'h0;
			s_din <= 2'h0;
			s_lck <= 2'h0;
			s_oe <= 2'h3;
		end else begin
			s_clr <= {s_clr[0], clear_all_n};
			s_sck <= {s_sck[0], shift_clock};
			s_din <= {s_din[0], shift_data_in};
			s_lck <= {s_lck[0], latch_clock};
			s_oe <= {s_oe[0], output_enable_n};
		end
	end

	assign clr_n = s_clr[1];
	assign oe_n = s_oe[1];
	assign din = s_din[1];

	always_ff @(posedge clk) begin
		if (srst) begin
			sck_q <= 1'b0;
			lck_q <= 1'b0;
		end else begin
			sck_q <= s_sck[1];
			lck_q <= s_lck[1];
		end
	end

	assign sck_rise = s_sck[1] & ~sck_q;
	assign sck_fall = ~s_sck[1] & sck_q;
	assign lck_rise = s_lck[1] & ~lck_q;

	// shift register
	always_ff @(posedge clk) begin
		if (srst || !clr_n) begin
			shift_reg <= slrd_pkg::CLEAR_VALUE;
		end else if (sck_rise) begin
			shift_reg <= {shift_reg[STAGES-2:0], din};
		end
	end

	// cascade output moves half a shift-clock later for hold margin
	always_ff @(posedge clk) begin
		if (srst || !clr_n) begin
			cascade_data_out <= 1'b0;
		end else if (sck_fall) begin
			cascade_data_out <= shift_reg[STAGES-1];
		end
	end

	// storage latch; every latch edge is taken, but while the buffer is full
	// the word is not pushed and is lost from the stream, though the latch copies it
	assign push = lck_rise && buf_in_ready;
	always_ff @(posedge clk) begin
		if (srst || !clr_n) begin
			latch_reg <= slrd_pkg::CLEAR_VALUE;
		end else if (lck_rise) begin
			latch_reg <= shift_reg;
		end
	end

	// sinks: oe_n low pulls the pin low, so conducting = oe low
	always_ff @(posedge clk) begin
		if (srst) begin
			sink_channel_oe_n <= '1;
		end else begin
			for (int i = 0; i < STAGES; i++) begin
				sink_channel_oe_n[i] <= ~(clr_n & ~oe_n & latch_reg[i]);
			end
		end
	end
	assign sink_channel_outputs = '0;

	// two-entry buffer carrying each latched word out while it has room
	assign buf_in_ready = (buf_cnt != 2'd2);
	assign pop = word_valid && word_ready;
	always_ff @(posedge clk) begin
		if (srst) begin
			buf_cnt <= 2'd0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			buf_mem[wr_ptr] <= shift_reg;
		end
	end
	assign word_valid = (buf_cnt != 2'd0);
	always_ff @(posedge clk) begin
		if (srst) begin
			word_data <= '0;
		end else begin
			word_data <= buf_mem[next_rd()];
		end
	end

	function automatic logic next_rd();
		next_rd = pop ? ~rd_ptr : rd_ptr;
	endfunction

	// a low clear empties both register banks on the next cycle
	clear_shift_a: assert property (@(posedge clk) disable iff (srst)
		!clr_n |=> shift_reg == '0 && latch_reg == '0)
		else $error("clear did not empty registers");

	// a high enable pin turns every channel off
	off_when_dis_a: assert property (@(posedge clk) disable iff (srst)
		oe_n |=> sink_channel_oe_n == '1)
		else $error("channel on while disabled");

	// enabled channels mirror the latch one cycle later
	on_follows_a: assert property (@(posedge clk) disable iff (srst)
		clr_n && !oe_n |=> sink_channel_oe_n == ~$past(latch_reg))
		else $error("channel does not follow latch");

	// latch edge copies all stages at once
	latch_copy_a: assert property (@(posedge clk) disable iff (srst)
		lck_rise && clr_n |=> latch_reg == $past(shift_reg))
		else $error("latch did not copy stages");

	// shift edge moves every stage up by one
	shift_step_a: assert property (@(posedge clk) disable iff (srst)
		sck_rise && clr_n |=>
		shift_reg == {$past(shift_reg[STAGES-2:0]), $past(din)})
		else $error("shift step wrong");

	// outside clear, the cascade pin only moves on a falling shift edge
	casc_hold_a: assert property (@(posedge clk) disable iff (srst)
		!sck_fall && clr_n |=> $stable(cascade_data_out))
		else $error("cascade moved off falling edge");

	// cascade pin shows the top stage
	casc_tail_a: assert property (@(posedge clk) disable iff (srst)
		sck_fall && clr_n |=>
		cascade_data_out == $past(shift_reg[STAGES-1]))
		else $error("cascade not final stage");

	// nothing reaches the channels while clear is low
	pass_clear_a: assert property (@(posedge clk) disable iff (srst)
		!clr_n |=> sink_channel_oe_n == '1)
		else $error("latch passed during clear");

	// open-drain pins never drive high
	drain_low_a: assert property (@(posedge clk)
		sink_channel_outputs == '0)
		else $error("sink driven high");

	// each synchroniser stage follows the one before it
	sync_clr_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> s_clr[1] == $past(s_clr[0]))
		else $error("clear synchroniser broken");

	// shift clock synchroniser
	sync_sck_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> s_sck[1] == $past(s_sck[0]))
		else $error("shift clock synchroniser broken");

	// latch clock synchroniser
	sync_lck_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> s_lck[1] == $past(s_lck[0]))
		else $error("latch clock synchroniser broken");

	// data synchroniser keeps data aligned with the clock path
	sync_din_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> s_din[1] == $past(s_din[0]))
		else $error("data synchroniser broken");

	// enable synchroniser
	sync_oe_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> s_oe[1] == $past(s_oe[0]))
		else $error("enable synchroniser broken");

	// a rise needs a low-then-high pair on the synchronised pin
	sck_rise_a: assert property (@(posedge clk) disable iff (srst)
		sck_rise |-> s_sck[1] && !sck_q)
		else $error("false shift rise");

	// a fall needs a high-then-low pair
	sck_fall_a: assert property (@(posedge clk) disable iff (srst)
		sck_fall |-> !s_sck[1] && sck_q)
		else $error("false shift fall");

	// one shift edge cannot be both directions
	edge_excl_a: assert property (@(posedge clk) disable iff (srst)
		!(sck_rise && sck_fall))
		else $error("shift rise and fall together");

	// latch rise detection
	lck_rise_a: assert property (@(posedge clk) disable iff (srst)
		lck_rise |-> s_lck[1] && !lck_q)
		else $error("false latch rise");

	// a rise lasts one cycle, so one pin edge shifts once
	sck_once_a: assert property (@(posedge clk) disable iff (srst)
		sck_rise |=> !sck_rise)
		else $error("shift rise repeated");

	// one latch pin edge copies once
	lck_once_a: assert property (@(posedge clk) disable iff (srst)
		lck_rise |=> !lck_rise)
		else $error("latch rise repeated");

	// stages hold between shift edges
	shift_hold_a: assert property (@(posedge clk) disable iff (srst)
		!sck_rise && clr_n |=> $stable(shift_reg))
		else $error("stages moved without shift edge");

	// latch holds between latch edges
	latch_hold_a: assert property (@(posedge clk) disable iff (srst)
		!lck_rise && clr_n |=> $stable(latch_reg))
		else $error("latch moved without latch edge");

	// clear also empties the cascade pin
	clear_casc_a: assert property (@(posedge clk) disable iff (srst)
		!clr_n |=> !cascade_data_out)
		else $error("cascade kept during clear");

	// a conducting channel always had its latch bit set
	sink_bit_a: assert property (@(posedge clk) disable iff (srst)
		1'b1 |=> (~sink_channel_oe_n & ~$past(latch_reg)) == '0)
		else $error("channel on with bit zero");

	// buffer never holds more than two words
	buf_bound_a: assert property (@(posedge clk) disable iff (srst)
		buf_cnt <= 2'd2)
		else $error("buffer overfilled");

	// a full buffer takes no word, so none is overwritten
	full_block_a: assert property (@(posedge clk) disable iff (srst)
		buf_cnt == 2'd2 |-> !push)
		else $error("push into full buffer");

	// valid follows the fill count
	valid_cnt_a: assert property (@(posedge clk) disable iff (srst)
		word_valid == (buf_cnt != 2'd0))
		else $error("valid disagrees with count");

	// a lone push grows the count by one
	push_grow_a: assert property (@(posedge clk) disable iff (srst)
		push && !pop |=> buf_cnt == $past(buf_cnt) + 2'd1)
		else $error("push did not grow count");

	// a lone pop shrinks it by one
	pop_shrink_a: assert property (@(posedge clk) disable iff (srst)
		pop && !push |=> buf_cnt == $past(buf_cnt) - 2'd1)
		else $error("pop did not shrink count");

	// each push advances the write slot
	push_ptr_a: assert property (@(posedge clk) disable iff (srst)
		push |=> wr_ptr != $past(wr_ptr))
		else $error("write slot stuck");

	// each pop advances the read slot
	pop_ptr_a: assert property (@(posedge clk) disable iff (srst)
		pop |=> rd_ptr != $past(rd_ptr))
		else $error("read slot stuck");
endmodule

// file: slrd_host.sv
// Purpose: host pin model that shifts words in and latches them
// Assumes: pins move just after clk rise
// Notes: each pin level lasts at least 4 clk, above the 2 clk minimum
module slrd_host (
	// clock
	input wire logic clk,
	// serial pins
	output logic shift_clock,
	output logic shift_data_in,
	output logic latch_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		shift_clock = 1'b0;
		shift_data_in = 1'b0;
		latch_clock = 1'b0;
	end
	// first bit out lands in the last stage after twelve shifts
	task automatic send(input logic [11:0] w);
		for (int i = 11; i >= 0; i--) begin
			shift_data_in <= w[i];
			repeat (4) @(posedge clk);
			shift_clock <= 1'b1;
			repeat (4) @(posedge clk);
			shift_clock <= 1'b0;
		end
		repeat (4) @(posedge clk);
		latch_clock <= 1'b1;
		repeat (4) @(posedge clk);
		latch_clock <= 1'b0;
	endtask
endmodule

// file: slrd_driver_tb.sv
// Purpose: self-checking bench for the serial-in latch driver
// Assumes: receiver stalls while three words are latched
// Notes: queue model holds at most two buffered words
module slrd_driver_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, srst = 1'b1, clear_all_n = 1'b1;
	logic output_enable_n = 1'b0, word_ready = 1'b0;
	logic shift_clock, shift_data_in, latch_clock;
	logic cascade_data_out, word_valid;
	logic [11:0] sink_channel_outputs, sink_channel_oe_n, word_data, w;
	logic [11:0] q[$];
	int errors = 0, check_count = 0, seed = 9166;
	always #25 clk = ~clk;
	slrd_host host (.clk(clk), .shift_clock(shift_clock),
		.shift_data_in(shift_data_in), .latch_clock(latch_clock));
	slrd_driver DUT (.clk(clk), .srst(srst), .clear_all_n(clear_all_n),
		.shift_clock(shift_clock), .shift_data_in(shift_data_in),
		.latch_clock(latch_clock), .output_enable_n(output_enable_n),
		.cascade_data_out(cascade_data_out),
		.sink_channel_outputs(sink_channel_outputs),
		.sink_channel_oe_n(sink_channel_oe_n), .word_valid(word_valid),
		.word_data(word_data), .word_ready(word_ready));
	task automatic chk(input string n, input logic [11:0] e, s);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
		if (word_valid === 1'b1 && word_ready === 1'b1) begin
			chk("word", q[0], word_data);
			void'(q.pop_front());
		end
	initial begin
		#1000000;
		errors++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		for (int r = 0; r < 4; r++) begin
			for (int k = 0; k < 3; k++) begin
				w = 12'($random(seed));
				output_enable_n <= ^w;
				host.send(w);
				if (q.size() < 2)
					q.push_back(w);
				repeat (8) @(posedge clk);
				chk("sinks", output_enable_n ? 12'hfff : ~w, sink_channel_oe_n);
				chk("cascade", {11'h0, w[11]}, {11'h0, cascade_data_out});
				chk("drive", 12'h000, sink_channel_outputs);
			end
			// one-cycle ready pulses: the head word settles in between
			repeat (3) begin
				word_ready <= 1'b1;
				@(posedge clk);
				word_ready <= 1'b0;
				repeat (2) @(posedge clk);
			end
			chk("empty", 12'h000, {11'h0, word_valid});
		end
		clear_all_n <= 1'b0;
		output_enable_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("clear", 12'hfff, sink_channel_oe_n);
		chk("clear_cas", 12'h000, {11'h0, cascade_data_out});
		clear_all_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("reopen", 12'hfff, sink_channel_oe_n);
		wrap_up();
	end
endmodule
